// ==== serial_fraction_multiplier.sv ====
// sequential shift-and-add multiplier for signed complement fractions
// Behaviour
// - operands are 39 magnitude bits plus sign, complement form, magnitude below one
// - full product is 78 magnitude bits plus sign, magnitude below one
// - multiplier bits examined one per step, least significant first, toward sign
// - multiplier bit one: add multiplicand, then shift sum and multiplier right
// - multiplier bit zero: no add, only shift partial product and multiplier right
// - exactly 40 steps: 39 add-and-shift steps then one sign correction
// - final step adds multiplicand complement when multiplier sign is one
// - partial product cleared to zero before every multiplication
// - in add-and-shift steps, from the first multiplier one on, partial product sign forced to multiplicand sign
// - additions are modulo two, carry out of the sign position is dropped
// - round-off drops bits beyond 39 and sets bit 39 to one
// - multiplicand complement formed by inverting all bits then adding one
module serial_fraction_multiplier
	import frac_mul_pkg::*;
#(
	parameter int MAG_W = MAG_BITS
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic start,
	input wire logic [MAG_W:0] multiplicand,
	input wire logic [MAG_W:0] multiplier,
	input wire logic round_sel,
	output logic busy,
	output logic done,
	output logic [MAG_W:0] product_hi,
	output logic [MAG_W-1:0] product_lo
);

	localparam int W = MAG_W + 1;

	mul_state_e state_reg;
	logic [STEP_CNT_W-1:0] step_reg;
	logic [W-1:0] acc_reg;
	logic [W-1:0] mq_reg;
	logic [W-1:0] mcand_reg;
	logic round_reg;
	logic seen_one_reg;
	logic busy_reg;
	logic done_reg;
	logic [W-1:0] sum_w;
	logic [W-1:0] mcand_cpl_w;
	logic [W-1:0] corr_w;
	logic seen_one_next;
	logic accept_w;
	logic srst_d_reg;

	assign accept_w = start && (state_reg == ST_IDLE);

	// modulo-two add
	// the width of sum_w drops the carry out of the sign position
	assign sum_w = acc_reg + (mq_reg[0] ? mcand_reg : '0);

	assign mcand_cpl_w = (~mcand_reg) + W'(1);

	// correction term only for a negative multiplier
	assign corr_w = mq_reg[0] ? (acc_reg + mcand_cpl_w) : acc_reg;

	assign seen_one_next = seen_one_reg || mq_reg[0];

	// sequencing
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_reg <= ST_IDLE;
			step_reg <= STEP_CNT_RESET;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (start)
					begin
						state_reg <= ST_RUN;
						step_reg <= STEP_CNT_RESET;
					end
				end
				ST_RUN:
				begin
					if (step_reg == STEP_CNT_LAST)
						state_reg <= ST_CORR;
					step_reg <= step_reg + 6'h01;
				end
				ST_CORR:
				begin
					state_reg <= ST_IDLE;
					step_reg <= STEP_CNT_RESET;
				end
				default:
				begin
					state_reg <= ST_IDLE;
					step_reg <= STEP_CNT_RESET;
				end
			endcase
		end
	end

	// operand capture
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mcand_reg <= ACC_RESET;
			round_reg <= 1'b0;
		end
		else if (accept_w)
		begin
			mcand_reg <= multiplicand;
			round_reg <= round_sel;
		end
	end

	// partial product, multiplier and low product
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			acc_reg <= ACC_RESET;
			mq_reg <= MQ_RESET;
			seen_one_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (start)
					begin
						acc_reg <= ACC_RESET;
						mq_reg <= multiplier;
						seen_one_reg <= 1'b0;
					end
				end
				ST_RUN:
				begin
					// add when bit is one, then shift
					// shift only when bit is zero
					// sign follows multiplicand after first one
					acc_reg <= {seen_one_next ? mcand_reg[SIGN_POS] : sum_w[SIGN_POS],
						sum_w[W-1:1]};
					// next multiplier bit moves to position zero
					// low product bit fills the vacated top
					mq_reg <= {sum_w[0], mq_reg[W-1:1]};
					seen_one_reg <= seen_one_next;
				end
				ST_CORR:
				begin
					// round-off sets the 2^-39 bit, clears the low half
					if (round_reg)
					begin
						acc_reg <= corr_w | W'(1);
						mq_reg <= MQ_RESET;
					end
					else
						acc_reg <= corr_w;
				end
				default:
				begin
					acc_reg <= acc_reg;
				end
			endcase
		end
	end

	// handshake outputs
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			if (accept_w)
				busy_reg <= 1'b1;
			else if (state_reg == ST_CORR)
				busy_reg <= 1'b0;
			done_reg <= (state_reg == ST_CORR);
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
	assign product_hi = acc_reg;
	assign product_lo = mq_reg[W-1:1];

	// reset seen one edge late by the checks: a reset dropped on the edge still masks them
	always_ff @(posedge mclk)
	begin
		srst_d_reg <= srst;
	end

	// checks
	a_done_latency: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		accept_w |-> ##41 (done_reg && !busy_reg))
		else $error("done not seen one cycle after the fortieth step");

	a_done_single: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		done_reg |=> !done_reg)
		else $error("done longer than one cycle");

	a_acc_cleared: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		accept_w |=> (acc_reg == '0) && (mq_reg == $past(multiplier)))
		else $error("partial product not cleared at start");

	a_shift_only: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		(state_reg == ST_RUN) && !mq_reg[0] |=> acc_reg[W-2:0] == $past(acc_reg[W-1:1]))
		else $error("zero bit did not shift partial product");

	a_mq_shift: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		(state_reg == ST_RUN) |=> mq_reg[W-2:0] == $past(mq_reg[W-1:1]))
		else $error("multiplier not shifted right");

	a_sign_forced: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		(state_reg == ST_RUN) && (seen_one_reg || mq_reg[0])
		|=> acc_reg[SIGN_POS] == mcand_reg[SIGN_POS])
		else $error("sign not forced to multiplicand sign");

	a_zero_before_one: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		(state_reg == ST_RUN) && !seen_one_reg && mq_reg[0]
		|=> acc_reg == {mcand_reg[SIGN_POS], $past(mcand_reg[W-1:1])})
		else $error("first add did not load multiplicand half");

	a_corr_noop: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		(state_reg == ST_CORR) && !mq_reg[0] && !round_reg |=> acc_reg == $past(acc_reg))
		else $error("positive multiplier changed product at correction");

	a_round_bit: assert property (@(posedge mclk) disable iff (srst || srst_d_reg)
		done_reg && round_reg |-> product_hi[ROUND_POS] && (product_lo == '0))
		else $error("round-off result malformed");

	c_negative_mult: cover property (@(posedge mclk) disable iff (srst || srst_d_reg)
		(state_reg == ST_CORR) && mq_reg[0]);

	c_rounded: cover property (@(posedge mclk) disable iff (srst || srst_d_reg)
		done_reg && round_reg);

	c_back_to_back: cover property (@(posedge mclk) disable iff (srst || srst_d_reg)
		done_reg && start);

endmodule : serial_fraction_multiplier

// ==== frac_mul_pkg.sv ====
// constants and types shared by the serial fraction multiplier
package frac_mul_pkg;
	// magnitude bits of one operand
	localparam int MAG_BITS = 39;
	// operand width: sign plus magnitude
	localparam int WORD_BITS = MAG_BITS + 1;
	// conditional add-and-shift steps before the sign correction
	localparam int ADD_STEPS = MAG_BITS;
	// width of the step counter
	localparam int STEP_CNT_W = 6;
	// reset value of the step counter
	localparam logic [STEP_CNT_W-1:0] STEP_CNT_RESET = 6'h00;
	// last value of the step counter during the add-and-shift phase
	localparam logic [STEP_CNT_W-1:0] STEP_CNT_LAST = 6'(ADD_STEPS - 1);
	// value of the partial product before the first step
	localparam logic [WORD_BITS-1:0] ACC_RESET = 40'h00_0000_0000;
	// reset value of the multiplier and low-product shift register
	localparam logic [WORD_BITS-1:0] MQ_RESET = 40'h00_0000_0000;
	// bit position of the sign in an operand
	localparam int SIGN_POS = WORD_BITS - 1;
	// bit of the high product word that round-off sets (weight 2^-39)
	localparam int ROUND_POS = 0;
	// total cycles from an accepted start to the sign correction step; done follows one cycle later
	localparam int DONE_LATENCY = ADD_STEPS + 1;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_CORR
	} mul_state_e;
endpackage : frac_mul_pkg

// ==== mul_sequencer.sv ====
// sequencer model that issues multiply orders to the multiplier
module mul_sequencer
	import frac_mul_pkg::*;
(
	input wire logic mclk,
	input wire logic go,
	input wire logic [SIGN_POS:0] x_in,
	input wire logic [SIGN_POS:0] y_in,
	input wire logic r_in,
	output logic start = 1'b0,
	output logic [SIGN_POS:0] multiplicand = ACC_RESET,
	output logic [SIGN_POS:0] multiplier = ACC_RESET,
	output logic round_sel = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge mclk)
	begin
		start <= go;
		if (go)
		begin
			multiplicand <= y_in;
			multiplier <= x_in;
			round_sel <= r_in;
		end
		else if (start)
		begin
			// operands go stale once taken
			multiplicand <= ~multiplicand;
			multiplier <= ~multiplier;
			round_sel <= ~round_sel;
		end
	end
endmodule : mul_sequencer

// ==== tb.sv ====
// self-checking bench for the serial fraction multiplier
module tb
	import frac_mul_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic go = 1'b0;
	logic r_in = 1'b0;
	logic [SIGN_POS:0] x_in = ACC_RESET;
	logic [SIGN_POS:0] y_in = ACC_RESET;
	logic start, round_sel, busy, done;
	logic [SIGN_POS:0] multiplicand, multiplier, product_hi;
	logic [MAG_BITS-1:0] product_lo;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	always #50 mclk = ~mclk;
	mul_sequencer seq (.mclk(mclk), .go(go), .x_in(x_in), .y_in(y_in), .r_in(r_in),
		.start(start), .multiplicand(multiplicand), .multiplier(multiplier),
		.round_sel(round_sel));
	serial_fraction_multiplier #(.MAG_W(MAG_BITS)) DUT (.mclk(mclk), .srst(srst),
		.start(start), .multiplicand(multiplicand), .multiplier(multiplier),
		.round_sel(round_sel), .busy(busy), .done(done), .product_hi(product_hi),
		.product_lo(product_lo));
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_word(input logic [78:0] got, input logic [78:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: product %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	function automatic logic [78:0] prod(input logic [SIGN_POS:0] x,
		input logic [SIGN_POS:0] y, input logic r);
		logic signed [79:0] p;
		p = $signed(x) * $signed(y);
		if (r)
			return {p[78:40], 1'b1, 39'h0};
		return p[78:0];
	endfunction : prod
	task automatic start_op(input logic [SIGN_POS:0] x, input logic [SIGN_POS:0] y,
		input logic r);
		@(posedge mclk);
		go <= 1'b1;
		x_in <= x;
		y_in <= y;
		r_in <= r;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		#1;
		chk_bit(busy, 1'b1);
	endtask : start_op
	task automatic end_op(input logic [SIGN_POS:0] x, input logic [SIGN_POS:0] y,
		input logic r);
		repeat (39) @(posedge mclk);
		#1;
		chk_bit(done, 1'b0);
		@(posedge mclk);
		#1;
		chk_bit(done, 1'b1);
		chk_bit(busy, 1'b0);
		chk_word({product_hi, product_lo}, prod(x, y, r));
		@(posedge mclk);
		#1;
		chk_bit(done, 1'b0);
	endtask : end_op
	task automatic test_table();
		logic [SIGN_POS:0] xs [6] = '{40'h70_0000_0000, 40'hD0_0000_0000, 40'h00_0000_0000,
			40'h80_0000_0000, 40'h00_0000_0001, 40'hA5_5A5A_5A5A};
		logic [SIGN_POS:0] ys [6] = '{40'h90_0000_0000, 40'hB0_0000_0000, 40'h80_0000_0001,
			40'h7F_FFFF_FFFF, 40'hFF_FFFF_FFFF, 40'h3C_C3C3_C3C3};
		logic rs [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 6; i++)
		begin
			start_op(xs[i], ys[i], rs[i]);
			end_op(xs[i], ys[i], rs[i]);
		end
		$display("test_table done");
	endtask : test_table
	task automatic test_b2b();
		start_op(40'h12_3456_789A, 40'hC0_0000_0001, 1'b0);
		repeat (4) @(posedge mclk);
		// request while busy must be ignored
		go <= 1'b1;
		x_in <= 40'h7F_FFFF_FFFF;
		@(posedge mclk);
		go <= 1'b0;
		repeat (34) @(posedge mclk);
		go <= 1'b1;
		x_in <= 40'hFF_FFFF_FFFF;
		y_in <= 40'h80_0000_0000;
		r_in <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		#1;
		chk_bit(done, 1'b1);
		chk_word({product_hi, product_lo}, prod(40'h12_3456_789A, 40'hC0_0000_0001, 1'b0));
		@(posedge mclk);
		#1;
		chk_bit(busy, 1'b1);
		end_op(40'hFF_FFFF_FFFF, 40'h80_0000_0000, 1'b1);
		$display("test_b2b done");
	endtask : test_b2b
	task automatic test_reset();
		start_op(40'hC0_0000_0000, 40'hC0_0000_0000, 1'b0);
		repeat (20) @(posedge mclk);
		srst <= 1'b1;
		@(posedge mclk);
		srst <= 1'b0;
		#1;
		chk_bit(busy | done, 1'b0);
		chk_word({product_hi, product_lo}, 79'h0);
		start_op(40'h40_0000_0000, 40'h20_0000_0000, 1'b0);
		end_op(40'h40_0000_0000, 40'h20_0000_0000, 1'b0);
		$display("test_reset done");
	endtask : test_reset
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		test_table();
		test_b2b();
		test_reset();
		finish_test();
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			finish_test();
		end
	end
endmodule : tb
